// file: hw/ssp_bank.sv
// object dictionary bank: startup behaviour and profile objects
`timescale 1ns/1ps
module ssp_bank #(
  parameter logic [31:0] STARTUP_RESET = 32'h0000_0000,
  parameter logic [15:0] PRIMARY_KIND = 16'h005a
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // object access from the protocol engine
  input wire logic acc_req,
  input wire logic acc_wr,
  input wire logic [15:0] acc_index,
  input wire logic [7:0] acc_sub,
  input wire logic [31:0] acc_wdata,
  output logic acc_done,
  output logic [1:0] acc_status,
  output logic [31:0] acc_rdata,
  // network management
  input wire logic nmt_start_cmd,
  input wire logic nmt_preop_cmd,
  output logic nmt_operational,
  output logic nmt_start_all_tx,
  // configuration time stamp
  input wire logic cfg_stamp_wr,
  input wire logic [31:0] cfg_days_in,
  input wire logic [31:0] cfg_ms_in,
  output logic [31:0] cfg_days,
  output logic [31:0] cfg_ms
);
  // ==========================================
  // elaboration checks
  // unit default and kind readback only know these two kinds
  if (PRIMARY_KIND != ssp_pkg::KIND_PRESSURE &&
      PRIMARY_KIND != ssp_pkg::KIND_TEMP)
  begin : g_bad_kind
    $error("primary kind must be pressure or temperature");
  end
  // boot decoder would quietly treat any other code as pre-op
  if (STARTUP_RESET != ssp_pkg::START_PREOP &&
      STARTUP_RESET != ssp_pkg::START_OP_BCAST &&
      STARTUP_RESET != ssp_pkg::START_OP_QUIET)
  begin : g_bad_start
    $error("startup reset must be one of the three codes");
  end

  // ==========================================
  // reset release
  logic rst_m_q, rst_s_q;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  wire logic rst_n = rst_s_q; // synced active-low reset

  // ==========================================
  // state
  logic [31:0] start_q, start_d; // startup code
  logic [31:0] unit_q [2], unit_d [2]; // unit per channel
  logic [31:0] days_q, days_d, ms_q, ms_d; // config stamp
  ssp_pkg::ssp_nmt_type nmt_q, nmt_d; // boot, pre-op, operational
  logic bcast_q, bcast_d; // one-cycle start-all pulse
  logic done_q, done_d;
  logic [1:0] stat_q, stat_d;
  logic [31:0] rdata_q, rdata_d;

  // default unit follows channel kind; temp-only primary uses celsius
  localparam logic [31:0] UNIT_DFLT0 =
    (PRIMARY_KIND == ssp_pkg::KIND_TEMP) ? ssp_pkg::UNIT_DEGC :
    ssp_pkg::UNIT_BAR;

  // ==========================================
  // next-state logic
  always_comb
  begin
    start_d = start_q;
    unit_d = unit_q;
    days_d = days_q;
    ms_d = ms_q;
    nmt_d = nmt_q;
    bcast_d = 1'b0;
    done_d = 1'b0;
    stat_d = stat_q;
    rdata_d = rdata_q;
    // master-side stamp write; a config write below overrides it
    if (cfg_stamp_wr)
    begin
      days_d = cfg_days_in;
      ms_d = cfg_ms_in;
    end
    // nmt state machine
    case (nmt_q)
      ssp_pkg::ST_BOOT:
      begin
        if (start_q == ssp_pkg::START_OP_BCAST)
        begin
          nmt_d = ssp_pkg::ST_OPER;
          bcast_d = 1'b1;
        end
        else if (start_q == ssp_pkg::START_OP_QUIET)
          nmt_d = ssp_pkg::ST_OPER;
        else
          nmt_d = ssp_pkg::ST_PREOP;
      end
      ssp_pkg::ST_PREOP:
        if (nmt_start_cmd)
          nmt_d = ssp_pkg::ST_OPER;
      ssp_pkg::ST_OPER:
        if (nmt_preop_cmd)
          nmt_d = ssp_pkg::ST_PREOP;
      default:
        nmt_d = ssp_pkg::ST_BOOT;
    endcase
    // object access, answered one cycle later
    if (acc_req)
    begin
      done_d = 1'b1;
      stat_d = ssp_pkg::ACK_OK;
      rdata_d = 32'h0000_0000;
      case (acc_index)
        ssp_pkg::IDX_STARTUP:
          if (acc_sub != 8'h00)
            stat_d = ssp_pkg::ACK_NO_OBJ;
          else if (!acc_wr)
            rdata_d = start_q;
          else if (acc_wdata != ssp_pkg::START_PREOP &&
                   acc_wdata != ssp_pkg::START_OP_BCAST &&
                   acc_wdata != ssp_pkg::START_OP_QUIET)
            stat_d = ssp_pkg::ACK_BAD_VALUE;
          else
          begin
            start_d = acc_wdata;
            days_d = 32'h0000_0000;
            ms_d = 32'h0000_0000;
          end
        ssp_pkg::IDX_KIND, ssp_pkg::IDX_PERIOD, ssp_pkg::IDX_UNIT:
          if (acc_sub == 8'h00)
          begin
            if (acc_wr)
              stat_d = ssp_pkg::ACK_READ_ONLY;
            else
              rdata_d = {24'h00_0000, ssp_pkg::SUB_COUNT};
          end
          else if (acc_sub > ssp_pkg::SUB_COUNT)
            stat_d = ssp_pkg::ACK_NO_OBJ;
          else if (acc_index == ssp_pkg::IDX_UNIT)
          begin
            if (acc_wr)
            begin
              // store and clear the stamp; nothing else reads it
              unit_d[acc_sub[1]] = acc_wdata;
              days_d = 32'h0000_0000;
              ms_d = 32'h0000_0000;
            end
            else
              rdata_d = unit_q[acc_sub[1]];
          end
          else if (acc_wr)
            stat_d = ssp_pkg::ACK_READ_ONLY;
          else if (acc_index == ssp_pkg::IDX_KIND)
            rdata_d = {16'h0000, acc_sub[1] ? ssp_pkg::KIND_TEMP :
                       PRIMARY_KIND};
          else
            rdata_d = ssp_pkg::PERIOD_US;
        default:
          stat_d = ssp_pkg::ACK_NO_OBJ;
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_q <= STARTUP_RESET;
      unit_q[0] <= UNIT_DFLT0;
      unit_q[1] <= ssp_pkg::UNIT_DEGC;
      days_q <= 32'h0000_0000;
      ms_q <= 32'h0000_0000;
      nmt_q <= ssp_pkg::ST_BOOT;
      bcast_q <= 1'b0;
      done_q <= 1'b0;
      stat_q <= ssp_pkg::ACK_OK;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      start_q <= start_d;
      unit_q <= unit_d;
      days_q <= days_d;
      ms_q <= ms_d;
      nmt_q <= nmt_d;
      bcast_q <= bcast_d;
      done_q <= done_d;
      stat_q <= stat_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // outputs
  assign acc_done = done_q;
  assign acc_status = stat_q;
  assign acc_rdata = rdata_q;
  assign nmt_operational = (nmt_q == ssp_pkg::ST_OPER);
  assign nmt_start_all_tx = bcast_q;
  assign cfg_days = days_q;
  assign cfg_ms = ms_q;
endmodule : ssp_bank

// file: hw/ssp_pkg.sv
// constants for the startup and profile object bank
// How it works
// - code 0x00 stays pre-operational after power-on
// - code 0x02 goes operational, broadcasts start-all
// - code 0x08 goes operational, sends nothing
// - startup code is rw word, object 0x1F80
// - profile sub-index 0 reads constant 2
// - sub 1 primary, sub 2 secondary channel
// - sensor kind codes constant, read only
// - sample period constant 1000 us, read only
// - unit codes rw, default bar/celsius
// - unit write stores the value, which nothing else uses
// - config write clears stored date and time
package ssp_pkg;
  // ==========================================
  // object indices
  localparam logic [15:0] IDX_STARTUP = 16'h1f80;
  localparam logic [15:0] IDX_KIND = 16'h6110;
  localparam logic [15:0] IDX_PERIOD = 16'h6114;
  localparam logic [15:0] IDX_UNIT = 16'h6131;
  // ==========================================
  // startup codes
  localparam logic [31:0] START_PREOP = 32'h0000_0000;
  localparam logic [31:0] START_OP_BCAST = 32'h0000_0002;
  localparam logic [31:0] START_OP_QUIET = 32'h0000_0008;
  // ==========================================
  // profile constants and defaults
  localparam logic [7:0] SUB_COUNT = 8'h02;
  localparam logic [15:0] KIND_PRESSURE = 16'h005a;
  localparam logic [15:0] KIND_TEMP = 16'h0064;
  localparam logic [31:0] PERIOD_US = 32'h0000_03e8;
  localparam logic [31:0] UNIT_BAR = 32'h004e_0100;
  localparam logic [31:0] UNIT_DEGC = 32'h002d_0100;
  // ==========================================
  // access answer codes
  localparam logic [1:0] ACK_OK = 2'h0;
  localparam logic [1:0] ACK_NO_OBJ = 2'h1;
  localparam logic [1:0] ACK_READ_ONLY = 2'h2;
  localparam logic [1:0] ACK_BAD_VALUE = 2'h3;
  // nmt states seen by the block
  typedef enum logic [1:0] {ST_BOOT, ST_PREOP, ST_OPER} ssp_nmt_type;
endpackage : ssp_pkg

// file: verif/ssp_checker.sv
// port assertions for the object bank
`timescale 1ns/1ps
module ssp_checker (
  // clock, reset and request
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic acc_req,
  input wire logic acc_wr,
  input wire logic [15:0] acc_index,
  input wire logic [7:0] acc_sub,
  input wire logic [31:0] acc_wdata,
  // answer and stamp
  input wire logic acc_done,
  input wire logic [1:0] acc_status,
  input wire logic [31:0] acc_rdata,
  input wire logic [31:0] cfg_days
);
  wire rd = acc_req && !acc_wr;
  wire wr = acc_req && acc_wr;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // ====================
  // answer timing and contents
  a_done_next: assert property (acc_req |=> acc_done) else $error("late");
  a_done_idle: assert property (!acc_req |=> !acc_done) else $error("stray");
  a_sub_count: assert property (rd && acc_sub == 8'h00 &&
    acc_index inside {16'h6110, 16'h6114, 16'h6131}
    |=> acc_rdata == 32'h0000_0002) else $error("count");
  a_kind_sec: assert property (rd && acc_index == 16'h6110 &&
    acc_sub == 8'h02 |=> acc_rdata == 32'h0000_0064) else $error("kind");
  a_period_ro: assert property (rd && acc_index == 16'h6114 &&
    acc_sub inside {1, 2} |=> acc_rdata == 32'h0000_03e8)
    else $error("period");
  a_const_wr: assert property (wr && acc_sub inside {1, 2} &&
    acc_index inside {16'h6110, 16'h6114} |=> acc_status == 2'h2)
    else $error("const");
  a_bad_code: assert property (wr && acc_index == 16'h1f80 &&
    !(acc_wdata inside {0, 2, 8}) && acc_sub == 8'h00 |=> acc_status == 2'h3)
    else $error("code");
  a_stamp_clr: assert property (wr && acc_index == 16'h6131 &&
    acc_sub inside {1, 2} |=> cfg_days == 32'h0000_0000) else $error("stamp");
  c_bad: cover property (acc_done && acc_status == 2'h3);
  c_ro: cover property (acc_done && acc_status == 2'h2);
  c_unit: cover property (wr && acc_index == 16'h6131);
endmodule : ssp_checker
bind ssp_bank ssp_checker i_ssp_checker (.mclk(mclk), .rst_b(rst_b),
  .acc_req(acc_req), .acc_wr(acc_wr), .acc_index(acc_index),
  .acc_sub(acc_sub), .acc_wdata(acc_wdata), .acc_done(acc_done),
  .acc_status(acc_status), .acc_rdata(acc_rdata), .cfg_days(cfg_days));

// file: verif/ssp_master.sv
// network master model issuing object accesses
`timescale 1ns/1ps
module ssp_master (
  // clock
  input wire logic mclk,
  // access toward the bank
  output logic acc_req = 1'b0,
  output logic acc_wr = 1'b0,
  output logic [15:0] acc_index = 16'h0000,
  output logic [7:0] acc_sub = 8'h00,
  output logic [31:0] acc_wdata = 32'h0000_0000
);
  // hold through the taking edge, then scramble stale data
  task automatic xfer(input logic w, input logic [15:0] i,
    input logic [7:0] s, input logic [31:0] d);
  begin
    @(posedge mclk);
    acc_req <= 1'b1;
    acc_wr <= w;
    acc_index <= i;
    acc_sub <= s;
    acc_wdata <= d;
    @(posedge mclk);
    acc_req <= 1'b0;
    acc_wdata <= ~d;
  end
  endtask : xfer
endmodule : ssp_master

// file: verif/ssp_bank_tb_top.sv
// self-checking bench for the object bank
`timescale 1ns/1ps
module ssp_bank_tb_top;
  // ====================
  // stimulus and per-bank outputs
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic nmt_go = 1'b0;
  logic nmt_back = 1'b0; // master order back to pre-op
  logic cfg_stamp_wr = 1'b0;
  logic req, wr;
  logic [15:0] ix, ti;
  logic [7:0] sb;
  logic [31:0] wd, sc;
  logic done[3], op[3], tx[3];
  logic [1:0] st[3];
  logic [31:0] rd[3], days[3], ms[3];
  int n_tx[3] = '{0, 0, 0};
  int error_cnt = 0;
  int n_compared = 0;
  localparam logic [31:0] ER[9] = '{32'h0000_0002, 32'h0000_005a,
    32'h0000_0064, 32'h0000_0002, 32'h0000_03e8, 32'h0000_03e8,
    32'h0000_0002, 32'h004e_0100, 32'h002d_0100};
  always #2 mclk = ~mclk;
  ssp_master i_ssp_master (.mclk(mclk), .acc_req(req), .acc_wr(wr),
    .acc_index(ix), .acc_sub(sb), .acc_wdata(wd));
  for (genvar g = 0; g < 3; g++)
  begin : g_bank
    // startup codes 0x00, 0x02, 0x08
    ssp_bank #(.STARTUP_RESET(32'(g * g * 2))) i_ssp_bank (
      .mclk(mclk), .rst_b(rst_b), .acc_req(req), .acc_wr(wr),
      .acc_index(ix), .acc_sub(sb), .acc_wdata(wd), .acc_done(done[g]),
      .acc_status(st[g]), .acc_rdata(rd[g]), .nmt_start_cmd(nmt_go),
      .nmt_preop_cmd(nmt_back), .nmt_operational(op[g]),
      .nmt_start_all_tx(tx[g]), .cfg_stamp_wr(cfg_stamp_wr),
      .cfg_days_in(32'h0000_1234), .cfg_ms_in(32'h0005_6789),
      .cfg_days(days[g]), .cfg_ms(ms[g]));
    // count on the falling edge, away from the edge launching the pulse
    always @(negedge mclk)
      if (tx[g] === 1'b1)
        n_tx[g]++;
  end
  // wide enough for done, status and data in one word
  task automatic chk(input logic [34:0] g, input logic [34:0] e);
  begin
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  end
  endtask : chk
  // one access, then answer, status and data of bank 0
  task automatic acc(input logic w, input logic [15:0] i,
    input logic [7:0] s, input logic [31:0] d, input logic [1:0] es,
    input logic [31:0] er);
  begin
    i_ssp_master.xfer(w, i, s, d);
    #1;
    chk({done[0], st[0], rd[0]}, {1'b1, es, er});
  end
  endtask : acc
  task automatic close_out;
  begin
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask : close_out
  initial
  begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    for (int k = 0; k < 3; k++)
    begin
      chk(32'(op[k]), 32'(k > 0));
      chk(n_tx[k], 32'(k == 1));
    end
    for (int k = 0; k < 9; k++)
    begin
      ti = k < 3 ? 16'h6110 : (k < 6 ? 16'h6114 : 16'h6131);
      acc(0, ti, 8'(k % 3), 0, 0, ER[k]);
    end
    acc(0, 16'h6110, 8'h03, 0, 2'h1, 0);
    acc(1, 16'h6110, 8'h01, 1, 2'h2, 0);
    acc(1, 16'h6114, 8'h02, 1, 2'h2, 0);
    // codes 2, 8, then 0
    for (int k = 0; k < 3; k++)
    begin
      sc = 32'((k + 1) * (k + 1) * 2 % 18);
      acc(1, 16'h1f80, 8'h00, sc, 0, 0);
      acc(0, 16'h1f80, 8'h00, 0, 0, sc);
    end
    @(posedge mclk) cfg_stamp_wr <= 1'b1;
    @(posedge mclk) cfg_stamp_wr <= 1'b0;
    acc(1, 16'h1f80, 8'h00, 5, 2'h3, 0);
    acc(0, 16'h1f80, 8'h00, 0, 0, 0);
    // a refused write leaves the stamp alone
    chk(days[0], 32'h0000_1234);
    chk(ms[0], 32'h0005_6789);
    acc(1, 16'h6131, 8'h02, 32'h1234_5678, 0, 0);
    chk(days[0] | ms[0], 0);
    acc(0, 16'h6131, 8'h02, 0, 0, 32'h1234_5678);
    acc(0, 16'h6131, 8'h01, 0, 0, 32'h004e_0100);
    acc(0, 16'h6114, 8'h02, 0, 0, 32'h0000_03e8);
    @(posedge mclk) nmt_go <= 1'b1;
    @(posedge mclk) nmt_go <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(op[0]), 1);
    @(posedge mclk) nmt_back <= 1'b1;
    @(posedge mclk) nmt_back <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(op[1]), 0);
    // second power-on: boot choice and defaults come back
    @(posedge mclk) rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(32'(op[1]), 1);
    chk(n_tx[1], 2);
    chk(n_tx[2], 0);
    acc(0, 16'h6131, 8'h02, 0, 0, 32'h002d_0100);
    acc(0, 16'h1f80, 8'h00, 0, 0, 0);
    close_out();
  end
  // hang guard, far beyond the roughly 75 cycles needed
  initial
  begin
    #4000;
    error_cnt++;
    $display("[FAIL] %0t watchdog", $time);
    close_out();
  end
endmodule : ssp_bank_tb_top
